// File: logic/pmon_map.svh
`ifndef PMON_MAP_SVH
`define PMON_MAP_SVH
// register byte offsets
`define PMON_OFF_DEV_CFG 8'h00
`define PMON_OFF_ADC_CFG 8'h04
`define PMON_OFF_SHUNT_CAL 8'h08
`define PMON_OFF_SHUNT_RES 8'h0c
`define PMON_OFF_BUS_RES 8'h10
`define PMON_OFF_TEMP_RES 8'h14
`define PMON_OFF_CURR_RES 8'h18
`define PMON_OFF_PWR_RES 8'h1c
`define PMON_OFF_ALERT_CFG 8'h20
`define PMON_OFF_SHUNT_LIM 8'h24
`define PMON_OFF_BUS_LIM 8'h28
`define PMON_OFF_IRQ_STAT 8'h2c
`define PMON_OFF_IRQ_CLR 8'h30
`define PMON_OFF_IRQ_EN 8'h34
// field positions
`define PMON_DEV_RANGE_BIT 4
`define PMON_ALERT_SEL_BIT 0
`define PMON_IRQ_DONE_BIT 0
`define PMON_IRQ_SOVR_BIT 1
`define PMON_IRQ_BOVR_BIT 2
`define PMON_CAL_SHIFT 11
`define PMON_PWR_SHIFT 8
// reset values
`define PMON_RST_DEV_CFG 16'h0000
`define PMON_RST_ADC_CFG 16'hfb68
`define PMON_RST_SHUNT_CAL 16'h0000
`define PMON_RST_ALERT_CFG 16'h0000
`define PMON_RST_LIMIT 16'h7fff
// conversion times in microseconds and clock rate
`define PMON_CLK_MHZ 25
`define PMON_CT0_US 50
`define PMON_CT1_US 84
`define PMON_CT2_US 150
`define PMON_CT3_US 280
`define PMON_CT4_US 540
`define PMON_CT5_US 1052
`define PMON_CT6_US 2074
`define PMON_CT7_US 4120
`endif

// File: logic/pmon_pkg.sv
package pmon_pkg;
  // conversion sequencer states, also the channel being converted
  typedef enum logic [1:0] {
    PMON_ST_IDLE = 2'b00,
    PMON_ST_SHUNT = 2'b01,
    PMON_ST_BUS = 2'b10,
    PMON_ST_TEMP = 2'b11
  } pmon_st_t;
  // one set of channel results, two's complement each
  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] temp;
  } pmon_meas_t;
  // adc settings register layout
  typedef struct packed {
    logic [3:0] mode;
    logic [2:0] ct_bus;
    logic [2:0] ct_shunt;
    logic [2:0] ct_temp;
    logic [2:0] avg;
  } pmon_adc_cfg_t;
endpackage

// File: logic/pmon_conv.sv
`timescale 1ns/1ns
`include "pmon_map.svh"
module pmon_conv #(
  parameter int CYC_PER_US = `PMON_CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire pmon_pkg::pmon_adc_cfg_t cfg,
  input wire logic trig,
  // raw adc codes from the converter
  input wire logic [15:0] shunt_code,
  input wire logic [15:0] bus_code,
  input wire logic [15:0] temp_code,
  // results
  output pmon_pkg::pmon_meas_t meas,
  output logic done,
  output pmon_pkg::pmon_st_t chan
);
  // conversion length of one channel in clock cycles
  function automatic logic [23:0] ct_cycles(input logic [2:0] sel);
    int us;
    case (sel)
      3'h0: us = `PMON_CT0_US;
      3'h1: us = `PMON_CT1_US;
      3'h2: us = `PMON_CT2_US;
      3'h3: us = `PMON_CT3_US;
      3'h4: us = `PMON_CT4_US;
      3'h5: us = `PMON_CT5_US;
      3'h6: us = `PMON_CT6_US;
      default: us = `PMON_CT7_US;
    endcase
    return 24'(us * CYC_PER_US);
  endfunction

  // averaging count as a shift: 1,4,16,64,128,256,512,1024
  function automatic logic [3:0] avg_shift(input logic [2:0] sel);
    case (sel)
      3'h0: return 4'h0;
      3'h1: return 4'h2;
      3'h2: return 4'h4;
      3'h3: return 4'h6;
      default: return 4'(sel) + 4'h3;
    endcase
  endfunction

  // first enabled channel after 'from', idle at the end of a pass
  function automatic pmon_pkg::pmon_st_t next_ch(input logic [1:0] from,
                                                 input logic [2:0] en);
    next_ch = pmon_pkg::PMON_ST_IDLE;
    if (from < 2'h3 && en[2]) next_ch = pmon_pkg::PMON_ST_TEMP;
    if (from < 2'h2 && en[1]) next_ch = pmon_pkg::PMON_ST_BUS;
    if (from < 2'h1 && en[0]) next_ch = pmon_pkg::PMON_ST_SHUNT;
  endfunction

  pmon_pkg::pmon_meas_t sync1_reg, sync2_reg; // pin synchroniser pair
  pmon_pkg::pmon_st_t st_reg, st_next;
  logic [23:0] cnt_reg, cnt_next; // cycles into this conversion
  logic [9:0] pass_reg, pass_next; // passes averaged so far
  logic [2:0][25:0] acc_reg, acc_next; // per channel sums, 0 shunt
  pmon_pkg::pmon_meas_t meas_reg, meas_next;
  logic done_reg, done_next;
  logic pend_reg, pend_next; // one-shot request waiting

  // codes come from the analog side, so two flops before use
  always_ff @(posedge aclk) begin
    sync1_reg <= {shunt_code, bus_code, temp_code};
    sync2_reg <= sync1_reg;
  end

  // sequencer: each channel converts for its own time
  always_comb begin
    logic [2:0] ct_sel;
    logic [15:0] sample;
    logic [1:0] idx;
    logic [3:0] sh;
    ct_sel = cfg.ct_temp;
    sample = sync2_reg.temp;
    idx = 2'(st_reg) - 2'h1;
    sh = avg_shift(cfg.avg);
    st_next = st_reg;
    cnt_next = cnt_reg;
    pass_next = pass_reg;
    acc_next = acc_reg;
    meas_next = meas_reg;
    done_next = 1'b0;
    pend_next = pend_reg | trig;
    case (st_reg)
      pmon_pkg::PMON_ST_SHUNT: begin
        ct_sel = cfg.ct_shunt;
        sample = sync2_reg.shunt;
      end
      pmon_pkg::PMON_ST_BUS: begin
        ct_sel = cfg.ct_bus;
        sample = sync2_reg.bus;
      end
      default: begin
        ct_sel = cfg.ct_temp;
        sample = sync2_reg.temp;
      end
    endcase
    case (st_reg)
      pmon_pkg::PMON_ST_IDLE: begin
        cnt_next = 24'h0;
        pass_next = 10'h0;
        // continuous mode restarts on its own, else wait for a trigger
        if (cfg.mode[3] || pend_reg) begin
          st_next = next_ch(2'h0, cfg.mode[2:0]);
          pend_next = trig;
        end
      end
      default: begin
        // >= so a shortened time mid-conversion cannot overrun
        if (cnt_reg >= ct_cycles(ct_sel) - 24'h1) begin
          acc_next[idx] = acc_reg[idx] + 26'($signed(sample));
          cnt_next = 24'h0;
          st_next = next_ch(2'(st_reg), cfg.mode[2:0]);
          if (st_next == pmon_pkg::PMON_ST_IDLE) begin
            if (pass_reg >= 10'((11'h1 << sh) - 11'h1)) begin
              // only enabled channels refresh, others keep the last value
              if (cfg.mode[0])
                meas_next.shunt = 16'($signed(acc_next[0]) >>> sh);
              if (cfg.mode[1])
                meas_next.bus = 16'($signed(acc_next[1]) >>> sh);
              if (cfg.mode[2])
                meas_next.temp = 16'($signed(acc_next[2]) >>> sh);
              acc_next = '0;
              pass_next = 10'h0;
              done_next = 1'b1;
              if (cfg.mode[3])
                st_next = next_ch(2'h0, cfg.mode[2:0]);
            end else begin
              pass_next = pass_reg + 10'h1;
              st_next = next_ch(2'h0, cfg.mode[2:0]);
            end
          end
        end else begin
          cnt_next = cnt_reg + 24'h1;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= pmon_pkg::PMON_ST_IDLE;
      cnt_reg <= 24'h0;
      pass_reg <= 10'h0;
      acc_reg <= '0;
      meas_reg <= '0;
      done_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pass_reg <= pass_next;
      acc_reg <= acc_next;
      meas_reg <= meas_next;
      done_reg <= done_next;
      pend_reg <= pend_next;
    end
  end

  assign meas = meas_reg;
  assign done = done_reg;
  assign chan = st_reg;
endmodule // pmon_conv

// File: logic/pmon_top.sv
// Summary of operation
// - conversion time and averaging set independently
// - shunt and bus have separate conversion times
// - shunt range bit picks wide or narrow
// - reset loads both settings registers' defaults
// - default: wide range, continuous three-channel conversion
// - zero calibration forces current and power zero
// - power computed only once calibration programmed
// - alert selects limit event or conversion ready
// - results are two's complement values
// - limit registers return to defaults at reset
`timescale 1ns/1ns
`include "pmon_map.svh"
module pmon_top #(
  parameter int CYC_PER_US = `PMON_CLK_MHZ,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter side
  input wire logic [15:0] shunt_code,
  input wire logic [15:0] bus_code,
  input wire logic [15:0] temp_code,
  output logic adc_range,
  output pmon_pkg::pmon_st_t adc_chan,
  // alert and interrupt
  output logic alert,
  output logic irq
);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = data[7:0];
    if (strb[1]) merge16[15:8] = data[15:8];
  endfunction

  // true when an offset is one the slave answers
  function automatic logic mapped(input logic [7:0] a);
    return a <= `PMON_OFF_IRQ_EN && a[1:0] == 2'h0;
  endfunction

  // write channel holding registers
  logic aw_hold_reg, aw_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  // read channel registers
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // software-visible settings
  logic [15:0] dev_cfg_reg, dev_cfg_next;
  logic [15:0] adc_cfg_reg, adc_cfg_next;
  logic [15:0] cal_reg, cal_next;
  logic [15:0] alert_cfg_reg, alert_cfg_next;
  logic [15:0] slim_reg, slim_next; // shunt over limit
  logic [15:0] blim_reg, blim_next; // bus over limit
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [2:0] irq_en_reg, irq_en_next;
  // derived results
  logic [15:0] curr_reg, curr_next;
  logic [23:0] pwr_reg, pwr_next;
  logic alert_reg, alert_next;
  logic irq_reg, irq_next;
  logic trig_reg, trig_next; // one-shot start on adc settings write
  // sequencer outputs
  pmon_pkg::pmon_meas_t meas;
  logic conv_done;
  logic do_write;
  logic [31:0] cur_x_cal, cur_x_bus;
  logic [15:0] curr_calc;

  // conversion sequencer and result averaging
  pmon_conv #(
    .CYC_PER_US(CYC_PER_US)
  ) u_conv (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(pmon_pkg::pmon_adc_cfg_t'(adc_cfg_reg)),
    .trig(trig_reg),
    .shunt_code(shunt_code),
    .bus_code(bus_code),
    .temp_code(temp_code),
    .meas(meas),
    .done(conv_done),
    .chan(adc_chan)
  );

  // a write completes once both halves are held and no response waits
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

  // current and power arithmetic, both ride on the calibration value
  always_comb begin
    cur_x_cal = 32'($signed(meas.shunt) * $signed({1'b0, cal_reg[14:0]}));
    curr_calc = cur_x_cal[`PMON_CAL_SHIFT+15:`PMON_CAL_SHIFT];
    if (cal_reg[14:0] == 15'h0)
      curr_calc = 16'h0;
    cur_x_bus = 32'($signed(curr_calc) * $signed(meas.bus));
  end

  // write channel: address and data accepted in either order
  always_comb begin
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // read channel: data one cycle after the address is taken
  always_comb begin
    logic [7:0] a;
    a = 8'(s_axi_araddr);
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0;
      if (a == `PMON_OFF_DEV_CFG) rdata_next[15:0] = dev_cfg_reg;
      else if (a == `PMON_OFF_ADC_CFG) rdata_next[15:0] = adc_cfg_reg;
      else if (a == `PMON_OFF_SHUNT_CAL) rdata_next[15:0] = cal_reg;
      else if (a == `PMON_OFF_SHUNT_RES) rdata_next[15:0] = meas.shunt;
      else if (a == `PMON_OFF_BUS_RES) rdata_next[15:0] = meas.bus;
      else if (a == `PMON_OFF_TEMP_RES) rdata_next[15:0] = meas.temp;
      else if (a == `PMON_OFF_CURR_RES) rdata_next[15:0] = curr_reg;
      else if (a == `PMON_OFF_PWR_RES) rdata_next[23:0] = pwr_reg;
      else if (a == `PMON_OFF_ALERT_CFG) rdata_next[15:0] = alert_cfg_reg;
      else if (a == `PMON_OFF_SHUNT_LIM) rdata_next[15:0] = slim_reg;
      else if (a == `PMON_OFF_BUS_LIM) rdata_next[15:0] = blim_reg;
      else if (a == `PMON_OFF_IRQ_STAT) rdata_next[2:0] = irq_stat_reg;
      else if (a == `PMON_OFF_IRQ_EN) rdata_next[2:0] = irq_en_reg;
      else if (a == `PMON_OFF_IRQ_CLR) rdata_next = 32'h0; // write-only
      else rresp_next = RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // settings, results and events
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    ev = 3'h0;
    clr = 3'h0;
    dev_cfg_next = dev_cfg_reg;
    adc_cfg_next = adc_cfg_reg;
    cal_next = cal_reg;
    alert_cfg_next = alert_cfg_reg;
    slim_next = slim_reg;
    blim_next = blim_reg;
    irq_en_next = irq_en_reg;
    curr_next = curr_reg;
    pwr_next = pwr_reg;
    trig_next = 1'b0;
    if (do_write) begin
      if (awaddr_reg == `PMON_OFF_DEV_CFG) begin
        dev_cfg_next = merge16(dev_cfg_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == `PMON_OFF_ADC_CFG) begin
        adc_cfg_next = merge16(adc_cfg_reg, wdata_reg, wstrb_reg);
        trig_next = 1'b1;
      end else if (awaddr_reg == `PMON_OFF_SHUNT_CAL) begin
        cal_next = merge16(cal_reg, wdata_reg, wstrb_reg) & 16'h7fff;
      end else if (awaddr_reg == `PMON_OFF_ALERT_CFG) begin
        alert_cfg_next = merge16(alert_cfg_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == `PMON_OFF_SHUNT_LIM) begin
        slim_next = merge16(slim_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == `PMON_OFF_BUS_LIM) begin
        blim_next = merge16(blim_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == `PMON_OFF_IRQ_EN) begin
        if (wstrb_reg[0]) irq_en_next = wdata_reg[2:0];
      end else if (awaddr_reg == `PMON_OFF_IRQ_CLR) begin
        if (wstrb_reg[0]) clr = wdata_reg[2:0];
      end
    end
    // new results: current, power and limit checks
    if (conv_done) begin
      curr_next = curr_calc;
      pwr_next = cur_x_bus[`PMON_PWR_SHIFT+23:`PMON_PWR_SHIFT];
      if (cal_reg[14:0] == 15'h0)
        pwr_next = 24'h0;
      ev[`PMON_IRQ_DONE_BIT] = 1'b1;
      ev[`PMON_IRQ_SOVR_BIT] = $signed(meas.shunt) > $signed(slim_reg);
      ev[`PMON_IRQ_BOVR_BIT] = $signed(meas.bus) > $signed(blim_reg);
    end
    // a new event outranks a clear in the same cycle
    irq_stat_next = (irq_stat_reg & ~clr) | ev;
    irq_next = |(irq_stat_next & irq_en_next);
    if (alert_cfg_next[`PMON_ALERT_SEL_BIT])
      alert_next = irq_stat_next[`PMON_IRQ_DONE_BIT];
    else
      alert_next = irq_stat_next[`PMON_IRQ_SOVR_BIT] |
                   irq_stat_next[`PMON_IRQ_BOVR_BIT];
  end

  // every register restarts from its power-on value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
      dev_cfg_reg <= `PMON_RST_DEV_CFG;
      adc_cfg_reg <= `PMON_RST_ADC_CFG;
      cal_reg <= `PMON_RST_SHUNT_CAL;
      alert_cfg_reg <= `PMON_RST_ALERT_CFG;
      slim_reg <= `PMON_RST_LIMIT;
      blim_reg <= `PMON_RST_LIMIT;
      irq_stat_reg <= 3'h0;
      irq_en_reg <= 3'h0;
      curr_reg <= 16'h0;
      pwr_reg <= 24'h0;
      alert_reg <= 1'b0;
      irq_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      dev_cfg_reg <= dev_cfg_next;
      adc_cfg_reg <= adc_cfg_next;
      cal_reg <= cal_next;
      alert_cfg_reg <= alert_cfg_next;
      slim_reg <= slim_next;
      blim_reg <= blim_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      curr_reg <= curr_next;
      pwr_reg <= pwr_next;
      alert_reg <= alert_next;
      irq_reg <= irq_next;
      trig_reg <= trig_next;
    end
  end

  // bus handshakes, ready low while a half is held
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // front end gain: 0 is the wide range, 1 the narrow one
  assign adc_range = dev_cfg_reg[`PMON_DEV_RANGE_BIT];
  assign alert = alert_reg;
  assign irq = irq_reg;
endmodule // pmon_top

// File: testbench/pmon_checker.sv
`timescale 1ns/1ns
module pmon_checker #(
  parameter int CYC_PER_US = 25,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter and alert side
  input wire logic adc_range,
  input wire pmon_pkg::pmon_st_t adc_chan,
  input wire logic alert,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken on one edge, as the host offers them
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // no write in the last two cycles, so a clear cannot be under way
  sequence no_write;
    !s_axi_awvalid && !$past(s_axi_awvalid) && !$past(s_axi_awvalid, 2) && !s_axi_bvalid;
  endsequence
  // reset itself is watched, so it must not disable this one
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !alert && !irq && !adc_range && adc_chan == pmon_pkg::PMON_ST_IDLE)
    else $error("outputs not quiet after reset");
  a_conv_start: assert property ($rose(aresetn) |-> ##[0:8]
    adc_chan == pmon_pkg::PMON_ST_SHUNT) else $error("no conversion after reset");
  a_chan_order: assert property ($past(adc_chan) == pmon_pkg::PMON_ST_SHUNT &&
    adc_chan != pmon_pkg::PMON_ST_SHUNT |-> adc_chan inside {pmon_pkg::PMON_ST_BUS,
    pmon_pkg::PMON_ST_IDLE}) else $error("bus does not follow shunt");
  a_alert_sticky: assert property (alert ##0 no_write |=> alert)
    else $error("alert dropped without clear");
  a_irq_sticky: assert property (irq ##0 no_write |=> irq)
    else $error("irq dropped without clear");
  a_write_resp: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_bresp_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_lat: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_rresp_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while data pending");
endmodule // pmon_checker
bind pmon_top pmon_checker #(.CYC_PER_US(CYC_PER_US), .ADDR_W(ADDR_W)) pmon_checker_inst (.*);

// File: testbench/pmon_host.sv
`timescale 1ns/1ns
module pmon_host (
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus from time zero; protection and strobes never change
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
  end
  // one write; released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  // one read; data and response taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule // pmon_host

// File: testbench/tb_top.sv
`timescale 1ns/1ns
`include "pmon_map.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
  logic aclk, aresetn, adc_range, alert, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] shunt_code, bus_code, temp_code;
  pmon_pkg::pmon_st_t adc_chan, prev;
  int err_count, samples_checked, cyc, run, len_sh, len_bu, n_sh, n0;
  longint p;
  logic [31:0] mdl [int]; // register model keyed by byte offset
  logic [7:0] res_a [6] = '{`PMON_OFF_SHUNT_RES, `PMON_OFF_BUS_RES, `PMON_OFF_TEMP_RES,
    `PMON_OFF_CURR_RES, `PMON_OFF_PWR_RES, `PMON_OFF_SHUNT_CAL};
  // one cycle per microsecond keeps conversions short
  pmon_top #(.CYC_PER_US(1)) pmon_top_inst (.*);
  pmon_host pmon_host_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, and lengths of the shunt and bus conversion slots
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
    prev <= adc_chan;
    if (adc_chan != prev) begin
      if (prev == pmon_pkg::PMON_ST_SHUNT) len_sh = run;
      if (prev == pmon_pkg::PMON_ST_BUS) len_bu = run;
      if (adc_chan == pmon_pkg::PMON_ST_SHUNT) n_sh++;
      run = 1;
    end else run++;
  end
  task automatic mw(input logic [7:0] a, input logic [31:0] v);
    mdl[a] = v;
    pmon_host_inst.wr(a, v, r);
    `CHK("bresp", 2'b00, r)
  endtask
  task automatic mr(input logic [7:0] a);
    pmon_host_inst.rd(a, d, r);
    `CHK("rdata", mdl[a], d)
  endtask
  // every supply cycle starts from defaults, so the model does too
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    mdl.delete();
    mdl[`PMON_OFF_DEV_CFG] = 32'h0;
    mdl[`PMON_OFF_ADC_CFG] = 32'hfb68;
    mdl[`PMON_OFF_SHUNT_CAL] = 32'h0;
    mdl[`PMON_OFF_ALERT_CFG] = 32'h0;
    mdl[`PMON_OFF_SHUNT_LIM] = 32'h7fff;
    mdl[`PMON_OFF_BUS_LIM] = 32'h7fff;
    mdl[`PMON_OFF_IRQ_EN] = 32'h0;
    foreach (mdl[k]) mr(k[7:0]);
    `CHK("range", 1'b0, adc_range)
  endtask
  // clear status, then wait for the chosen flag; a stale flag needs a cycle to fall
  task automatic wait_hi(input bit use_alert);
    pmon_host_inst.wr(`PMON_OFF_IRQ_CLR, 32'h7, r);
    repeat (2) @(posedge aclk);
    while (!(use_alert ? alert : irq)) @(posedge aclk);
  endtask
  initial begin
    seed = 32'hee1e;
    aresetn = 1'b0;
    {shunt_code, bus_code, temp_code} = '0;
    do_reset();
    // negative shunt reading, calibration still unprogrammed
    d = xs();
    shunt_code <= d[15:0] | 16'h8000;
    bus_code <= {2'b00, d[29:16]} | 16'h1;
    temp_code <= 16'(xs());
    mw(`PMON_OFF_IRQ_EN, 32'h1);
    mw(`PMON_OFF_ADC_CFG, 32'hf000);
    wait_hi(0);
    wait_hi(0);
    mdl[`PMON_OFF_SHUNT_RES] = shunt_code;
    mdl[`PMON_OFF_BUS_RES] = bus_code;
    mdl[`PMON_OFF_TEMP_RES] = temp_code;
    mdl[`PMON_OFF_CURR_RES] = 32'h0;
    mdl[`PMON_OFF_PWR_RES] = 32'h0;
    foreach (res_a[i]) mr(res_a[i]);
    // positive shunt with calibration; products stay positive
    d = xs();
    shunt_code <= {5'h0, d[10:0]};
    mw(`PMON_OFF_SHUNT_CAL, {17'h0, d[30:16]} | 32'h1);
    wait_hi(0);
    wait_hi(0);
    p = longint'(shunt_code) * mdl[`PMON_OFF_SHUNT_CAL];
    mdl[`PMON_OFF_SHUNT_RES] = shunt_code;
    mdl[`PMON_OFF_CURR_RES] = (p >> 11) & 32'hffff;
    mdl[`PMON_OFF_PWR_RES] = ((mdl[`PMON_OFF_CURR_RES] * bus_code) >> 8) & 32'hffffff;
    foreach (res_a[i]) mr(res_a[i]);
    mw(`PMON_OFF_DEV_CFG, 32'h10);
    mr(`PMON_OFF_DEV_CFG);
    `CHK("range", 1'b1, adc_range)
    // bus slot 84 against shunt slot 50, four passes per result
    mw(`PMON_OFF_ADC_CFG, 32'hf201);
    wait_hi(0);
    wait_hi(0);
    n0 = n_sh;
    wait_hi(0);
    `CHK("passes", 4, n_sh - n0)
    `CHK("slot_diff", 34, len_bu - len_sh)
    // alert as conversion-ready, then as limit event
    mw(`PMON_OFF_ALERT_CFG, 32'h1);
    wait_hi(1);
    `CHK("alert_ready", 1'b1, alert)
    mw(`PMON_OFF_ALERT_CFG, 32'h0);
    wait_hi(0);
    `CHK("alert_idle", 1'b0, alert)
    mw(`PMON_OFF_BUS_LIM, bus_code - 16'h1);
    mw(`PMON_OFF_IRQ_EN, 32'h4);
    wait_hi(0);
    `CHK("alert_limit", 1'b1, alert)
    `CHK("irq", 1'b1, irq)
    pmon_host_inst.rd(`PMON_OFF_IRQ_STAT, d, r);
    `CHK("bus_over", 1'b1, d[2])
    // unmapped places answer with an error; results ignore writes
    pmon_host_inst.rd(8'h38, d, r);
    `CHK("rresp", 2'b10, r)
    `CHK("rdata", 32'h0, d)
    pmon_host_inst.wr(8'h3c, 32'h1, r);
    `CHK("bresp", 2'b10, r)
    pmon_host_inst.wr(`PMON_OFF_SHUNT_RES, 32'h1234, r);
    mr(`PMON_OFF_SHUNT_RES);
    // a second power-up forgets settings, limits and calibration
    do_reset();
    give_verdict();
  end
endmodule // tb_top
